//--- design/evt_ctrl_pkg.sv
// constants shared by the two-stage event controller
// assumes one processor clock and a synchronous active-low reset
package evt_ctrl_pkg;
   localparam int unsigned NUM_EVENTS = 16;
   localparam int unsigned NUM_GP = 9;
   localparam int unsigned GP_BASE = 7;
   localparam int unsigned NUM_SRC = 32;
   localparam int unsigned NUM_ASSIGN = 4;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;

   // register indices on the mmr port
   localparam logic [3:0] IDX_LATCH = 4'h0;
   localparam logic [3:0] IDX_MASK = 4'h1;
   localparam logic [3:0] IDX_PENDING = 4'h2;
   localparam logic [3:0] IDX_PERIPH_MASK = 4'h3;
   localparam logic [3:0] IDX_PERIPH_STATUS = 4'h4;
   localparam logic [3:0] IDX_WAKEUP_EN = 4'h5;
   localparam logic [3:0] IDX_ASSIGN0 = 4'h6;
   localparam logic [3:0] IDX_ASSIGN3 = 4'h9;

   // event bit positions and groups
   localparam logic [15:0] ALWAYS_ON = 16'h0007;
   localparam logic [15:0] RESERVED_BITS = 16'h0010;
   localparam logic [15:0] GP_MASK = 16'hFF80;

   // values after reset
   localparam logic [15:0] LATCH_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] PENDING_RST = 16'h0000;
   localparam logic [31:0] PERIPH_MASK_RST = 32'h00000000;
   localparam logic [31:0] WAKEUP_EN_RST = 32'h00000000;
   // one nibble per source, value is the offset above the first general level
   localparam logic [3:0][31:0] ASSIGN_RST = {
      32'h00000000, 32'h00000087, 32'h66554443, 32'h32111100
   };

   // cycle figures
   localparam int unsigned EDGE_DETECT_CYCLES = 2;
   localparam int unsigned MIN_PEND_CYCLES = 3;
endpackage

//--- design/sic_cec_if.sv
// carrier between the system stage and the core stage
// assumes both ends sit on the processor clock
`timescale 1ns/1ps
interface sic_cec_if;
   logic [evt_ctrl_pkg::NUM_GP-1:0] routed;
   logic [evt_ctrl_pkg::NUM_GP-1:0] pending_gp;
   logic wr;
   logic [evt_ctrl_pkg::ADDR_W-1:0] addr;
   logic [evt_ctrl_pkg::DATA_W-1:0] wdata;
   logic [evt_ctrl_pkg::DATA_W-1:0] rdata;
   logic wakeup;

   modport sic (
      input wr, addr, wdata, pending_gp,
      output routed, rdata, wakeup
   );
   modport cec (
      output wr, addr, wdata, pending_gp,
      input routed, rdata, wakeup
   );
endinterface

//--- design/system_irq_stage.sv
// system stage: peripheral masking, status, wakeup and routing to core levels
// assumes raw peripheral lines are asynchronous to the processor clock
`timescale 1ns/1ps
module system_irq_stage (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [evt_ctrl_pkg::NUM_SRC-1:0] i_periph_irq,
   sic_cec_if.sic bus
);
   localparam int unsigned NS = evt_ctrl_pkg::NUM_SRC;
   localparam int unsigned NG = evt_ctrl_pkg::NUM_GP;

   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   logic [NS-1:0] mask_q;
   logic [NS-1:0] wake_en_q;
   logic [evt_ctrl_pkg::NUM_ASSIGN-1:0][31:0] assign_q;
   logic [NG-1:0] routed_q;
   logic [NG-1:0] pend_prev_q;
   logic wakeup_q;
   logic [NG-1:0][NS-1:0] sel;
   logic [NG-1:0] hit;
   logic [NS-1:0] pass;
   logic [NG-1:0] pend_rise;
   logic [3:0] aoff;
   logic assign_sel;
   logic assign_wr;

   // R9 mask passes source
   assign pass = sync2_q & mask_q;
   assign pend_rise = bus.pending_gp & ~pend_prev_q;
   assign aoff = bus.addr - evt_ctrl_pkg::IDX_ASSIGN0;
   assign assign_sel = (bus.addr >= evt_ctrl_pkg::IDX_ASSIGN0)
      && (bus.addr <= evt_ctrl_pkg::IDX_ASSIGN3);
   assign assign_wr = bus.wr && assign_sel;

   // R18 programmable level mapping
   for (genvar s = 0; s < NS; s++) begin : g_src
      logic [3:0] lvl;
      assign lvl = assign_q[s / 8][(s % 8) * 4 +: 4];
      for (genvar k = 0; k < NG; k++) begin : g_lvl
         assign sel[k][s] = pass[s] && (lvl == 4'(k));
      end
   end
   for (genvar k = 0; k < NG; k++) begin : g_hit
      assign hit[k] = |sel[k];
   end

   // R10 status is the live level
   assign bus.rdata = (bus.addr == evt_ctrl_pkg::IDX_PERIPH_MASK) ? mask_q :
      (bus.addr == evt_ctrl_pkg::IDX_PERIPH_STATUS) ? sync2_q :
      (bus.addr == evt_ctrl_pkg::IDX_WAKEUP_EN) ? wake_en_q :
      assign_sel ? assign_q[aoff[1:0]] : 32'h00000000;
   assign bus.routed = routed_q;
   assign bus.wakeup = wakeup_q;

   always_ff @(posedge i_ref_clk) begin
      sync1_q <= i_periph_irq;
      sync2_q <= sync1_q;
   end

   // R8 three per-source registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         mask_q <= evt_ctrl_pkg::PERIPH_MASK_RST;
         wake_en_q <= evt_ctrl_pkg::WAKEUP_EN_RST;
         assign_q <= evt_ctrl_pkg::ASSIGN_RST;
      end else begin
         if (bus.wr && bus.addr == evt_ctrl_pkg::IDX_PERIPH_MASK) begin
            mask_q <= bus.wdata;
         end
         if (bus.wr && bus.addr == evt_ctrl_pkg::IDX_WAKEUP_EN) begin
            wake_en_q <= bus.wdata;
         end
         if (assign_wr) begin
            assign_q[aoff[1:0]] <= bus.wdata;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         routed_q <= '0;
         pend_prev_q <= '0;
         wakeup_q <= 1'b0;
      end else begin
         // R12 pending rise acknowledges; one low cycle re-arms the edge
         routed_q <= hit & ~pend_rise;
         pend_prev_q <= bus.pending_gp;
         // R11 wake from sleep
         wakeup_q <= |(sync2_q & wake_en_q);
      end
   end

   property p_ack_gap;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (pend_rise != '0) |=> ((routed_q & $past(pend_rise)) == '0);
   endproperty
   a_ack_gap: assert property (p_ack_gap) // R12
      else $error("routed line not dropped on acknowledge");
endmodule

//--- design/event_controller.sv
// top of the two-stage event controller: core stage plus system stage
// assumes core control pulses are on the processor clock; fixed event pins are not
//
// Functional notes
// R1: sixteen-bit latch, mask, pending registers
// R2: latch sets on capture, clears on accept
// R3: software writes latch only where unmasked-off
// R4: mask one allows service, zero blocks; bits 0 to 2 are serviced whatever the mask holds
// R5: mask access only in supervisor mode
// R6: global enable and disable gate levels
// R7: pending tracks nested events, hardware updated
// R8: three 32-bit per-peripheral system registers
// R9: system mask passes or blocks sources
// R10: status reads live source level
// R11: wakeup enable lets source wake processor
// R12: pending contents acknowledge routed interrupts
// R13: rising edge latched after two cycles
// R14: latch clears when pending bit sets
// R15: further edge latched after pending sets
// R16: edge to pending at least three cycles
// R17: nine general levels below fixed events
// R18: assignment registers remap source levels
// R19: return clears active pending bit
`timescale 1ns/1ps
module event_controller (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [evt_ctrl_pkg::NUM_SRC-1:0] i_periph_irq,
   input wire logic [evt_ctrl_pkg::GP_BASE-1:0] i_fixed_evt,
   input wire logic i_sti,
   input wire logic i_cli,
   input wire logic i_core_ready,
   input wire logic i_return,
   input wire logic i_supervisor,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [evt_ctrl_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [evt_ctrl_pkg::DATA_W-1:0] i_reg_wdata,
   output logic [evt_ctrl_pkg::DATA_W-1:0] o_reg_rdata,
   output logic o_reg_err,
   output logic o_take,
   output logic [3:0] o_take_id,
   output logic [evt_ctrl_pkg::NUM_EVENTS-1:0] o_pending_events,
   output logic o_global_en,
   output logic o_wakeup
);
   localparam int unsigned NE = evt_ctrl_pkg::NUM_EVENTS;

   sic_cec_if bus ();

   system_irq_stage u_sic (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_periph_irq(i_periph_irq),
      .bus(bus)
   );

   logic [evt_ctrl_pkg::GP_BASE-1:0] fsync1_q;
   logic [evt_ctrl_pkg::GP_BASE-1:0] fsync2_q;
   logic [NE-1:0] in_q;
   logic [NE-1:0] prev_q;
   logic [NE-1:0] latch_q;
   logic [NE-1:0] latch_d;
   logic [NE-1:0] mask_q;
   logic [NE-1:0] pending_q;
   logic [NE-1:0] pending_d;
   logic global_en_q;
   logic [evt_ctrl_pkg::DATA_W-1:0] rdata_q;
   logic err_q;
   logic take_q;
   logic [3:0] take_id_q;
   logic wakeup_q;

   logic [NE-1:0] evt_in;
   logic [NE-1:0] edge_w;
   logic [NE-1:0] gate;
   logic [NE-1:0] eff_mask;
   logic [NE-1:0] cand;
   logic [3:0] best_idx;
   logic [3:0] act_idx;
   logic [NE-1:0] best_oh;
   logic [NE-1:0] act_oh;
   logic accept;
   logic ret;
   logic access;
   logic mapped;
   logic sic_sel;
   logic core_wr;
   logic latch_wr;
   logic mask_wr;
   logic [NE-1:0] sw_latch;
   logic [NE-1:0] wdata16;
   logic [evt_ctrl_pkg::DATA_W-1:0] rdata_d;

   // lowest index is the highest priority
   function automatic logic [3:0] low_idx(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // R17 fixed events below bit 7, nine general levels above
   assign evt_in = {bus.routed, fsync2_q} & ~evt_ctrl_pkg::RESERVED_BITS;
   // R13 edge seen in the same cycle the input register rises, one cycle after the input
   assign edge_w = in_q & ~prev_q;

   // R6 global gate on general levels only
   assign gate = global_en_q ? {NE{1'b1}} : ~evt_ctrl_pkg::GP_MASK;
   // R4 mask decides service above bit 2, latch is kept regardless
   assign eff_mask = (mask_q | evt_ctrl_pkg::ALWAYS_ON) & gate;
   assign cand = latch_q & eff_mask;
   assign best_idx = low_idx(cand);
   assign act_idx = low_idx(pending_q);
   assign best_oh = 16'h0001 << best_idx;
   assign act_oh = 16'h0001 << act_idx;
   // R16 accept only from an already latched bit, so three cycles at least
   assign accept = i_core_ready && (cand != '0)
      && ((pending_q == '0) || (best_idx < act_idx));
   assign ret = i_return && (pending_q != '0);

   // all registers are supervisor-only mmrs
   assign access = i_reg_wr || i_reg_rd;
   assign mapped = i_reg_addr <= evt_ctrl_pkg::IDX_ASSIGN3;
   assign sic_sel = (i_reg_addr >= evt_ctrl_pkg::IDX_PERIPH_MASK) && mapped;
   // R5 supervisor gate on writes
   assign core_wr = i_reg_wr && i_supervisor;
   assign latch_wr = core_wr && (i_reg_addr == evt_ctrl_pkg::IDX_LATCH);
   assign mask_wr = core_wr && (i_reg_addr == evt_ctrl_pkg::IDX_MASK);
   assign wdata16 = i_reg_wdata[NE-1:0];
   // R3 software reaches only bits whose mask is clear
   assign sw_latch = latch_wr ? ((latch_q & mask_q) | (wdata16 & ~mask_q)) : latch_q;

   // R2 clear on accept, R15 a new edge wins over that clear
   assign latch_d = (sw_latch & ~(accept ? best_oh : '0)) | edge_w;

   // R19 return retires the active level, R7 accept nests a new one
   assign pending_d = (pending_q & ~(ret ? act_oh : '0)) | (accept ? best_oh : '0);

   assign bus.wr = core_wr && sic_sel;
   assign bus.addr = i_reg_addr;
   assign bus.wdata = i_reg_wdata;
   // R12 system stage watches the general pending bits
   assign bus.pending_gp = pending_q[NE-1:evt_ctrl_pkg::GP_BASE];

   // R7 pending readable in supervisor mode only
   assign rdata_d = !(i_reg_rd && i_supervisor) ? 32'h00000000 :
      (i_reg_addr == evt_ctrl_pkg::IDX_LATCH) ? {16'h0000, latch_q} :
      (i_reg_addr == evt_ctrl_pkg::IDX_MASK) ? {16'h0000, mask_q} :
      (i_reg_addr == evt_ctrl_pkg::IDX_PENDING) ? {16'h0000, pending_q} :
      sic_sel ? bus.rdata : 32'h00000000;

   assign o_reg_rdata = rdata_q;
   assign o_reg_err = err_q;
   assign o_take = take_q;
   assign o_take_id = take_id_q;
   assign o_pending_events = pending_q;
   assign o_global_en = global_en_q;
   assign o_wakeup = wakeup_q;

   // fixed event pins come from outside the clock domain
   always_ff @(posedge i_ref_clk) begin
      fsync1_q <= i_fixed_evt;
      fsync2_q <= fsync1_q;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         in_q <= '0;
         prev_q <= '0;
      end else begin
         in_q <= evt_in;
         prev_q <= in_q;
      end
   end

   // R1 the three core registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         latch_q <= evt_ctrl_pkg::LATCH_RST;
         mask_q <= evt_ctrl_pkg::MASK_RST;
         pending_q <= evt_ctrl_pkg::PENDING_RST;
      end else begin
         latch_q <= latch_d;
         pending_q <= pending_d;
         if (mask_wr) begin
            mask_q <= wdata16 & ~evt_ctrl_pkg::RESERVED_BITS;
         end
      end
   end

   // R6 disable wins if both arrive together
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         global_en_q <= 1'b0;
      end else if (i_cli) begin
         global_en_q <= 1'b0;
      end else if (i_sti) begin
         global_en_q <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rdata_q <= 32'h00000000;
         err_q <= 1'b0;
         take_q <= 1'b0;
         take_id_q <= 4'h0;
         wakeup_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         err_q <= access && (!i_supervisor || !mapped);
         take_q <= accept;
         take_id_q <= accept ? best_idx : 4'h0;
         wakeup_q <= bus.wakeup;
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_edge_latch;
      (edge_w != '0) |=> ((latch_q & $past(edge_w)) == $past(edge_w));
   endproperty
   a_edge_latch: assert property (p_edge_latch) // R13
      else $error("detected edge did not set latch");

   property p_accept_clear;
      (accept && ((best_oh & edge_w) == '0)) |=> ((latch_q & $past(best_oh)) == '0);
   endproperty
   a_accept_clear: assert property (p_accept_clear) // R14
      else $error("latch bit kept after pending set");

   property p_accept_pend;
      accept |=> ((pending_q & $past(best_oh)) != '0) && take_q;
   endproperty
   a_accept_pend: assert property (p_accept_pend) // R7
      else $error("accepted event not pending");

   property p_mask_block;
      accept |-> ((best_oh & (mask_q | evt_ctrl_pkg::ALWAYS_ON)) != '0);
   endproperty
   a_mask_block: assert property (p_mask_block) // R4
      else $error("masked event was serviced");

   property p_global_gate;
      (accept && ((best_oh & evt_ctrl_pkg::GP_MASK) != '0)) |-> global_en_q;
   endproperty
   a_global_gate: assert property (p_global_gate) // R6
      else $error("general level taken while globally disabled");

   property p_user_mask;
      (i_reg_wr && !i_supervisor) |=> $stable(mask_q);
   endproperty
   a_user_mask: assert property (p_user_mask) // R5
      else $error("mask changed outside supervisor mode");

   property p_latch_guard;
      (latch_wr && !accept && (edge_w == '0))
      |=> ((latch_q & $past(mask_q)) == ($past(latch_q) & $past(mask_q)));
   endproperty
   a_latch_guard: assert property (p_latch_guard) // R3
      else $error("software altered an unmasked latch bit");

   property p_pend_hw;
      (!accept && !ret) |=> $stable(pending_q);
   endproperty
   a_pend_hw: assert property (p_pend_hw) // R7
      else $error("pending changed without accept or return");

   property p_return;
      (ret && !accept) |=> (pending_q == ($past(pending_q) & ~$past(act_oh)));
   endproperty
   a_return: assert property (p_return) // R19
      else $error("return did not retire the active level");

   property p_min_latency;
      ((edge_w & evt_ctrl_pkg::GP_MASK) != '0) |-> !accept || ((best_oh & edge_w) == '0)
         || ((latch_q & best_oh) != '0);
   endproperty
   a_min_latency: assert property (p_min_latency) // R16
      else $error("event taken in the cycle of its edge");
endmodule

//--- tb/irq_source_model.sv
// peripheral interrupt sources and the core pipeline's accept line
// assumes the bench sets source levels and stall on the processor clock
`timescale 1ns/1ps
module irq_source_model (
   input wire logic i_ref_clk,
   input wire logic [31:0] i_level,
   input wire logic i_stall,
   output logic [31:0] o_periph_irq,
   output logic o_core_ready
);
   initial o_periph_irq = 32'h00000000;
   // a source holds its line high until software clears it at the source
   always @(posedge i_ref_clk) begin
      o_periph_irq <= i_level;
   end
   assign o_core_ready = !i_stall;
endmodule

//--- tb/two_stage_event_controller_bench.sv
// self-checking bench for the event controller with a source model
// assumes a 50 MHz clock and register access in supervisor mode except in t_access
`timescale 1ns/1ps
module two_stage_event_controller_bench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic global_irq_enable_instr = 1'b0, global_irq_disable_instr = 1'b0, ret = 1'b0, sup = 1'b1, stall = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h00000000, level = 32'h00000000, periph_irq;
   logic [31:0] reg_rdata;
   logic reg_err, take, global_en, wakeup, core_ready;
   logic [3:0] take_id;
   logic [15:0] pending;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #10 ref_clk = ~ref_clk;

   irq_source_model u_irq_source_model (.i_ref_clk(ref_clk), .i_level(level),
      .i_stall(stall), .o_periph_irq(periph_irq), .o_core_ready(core_ready));
   // fixed core events are outside this bench's reach and stay low
   event_controller u_event_controller (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
      .i_periph_irq(periph_irq), .i_fixed_evt(7'h00), .i_sti(global_irq_enable_instr), .i_cli(global_irq_disable_instr),
      .i_core_ready(core_ready), .i_return(ret), .i_supervisor(sup), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .o_reg_err(reg_err), .o_take(take), .o_take_id(take_id),
      .o_pending_events(pending), .o_global_en(global_en), .o_wakeup(wakeup));

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // tests should end well under this many cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   // strobe for one cycle, answer is taken the cycle after
   task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
      e = reg_err;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      acc(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] q;
      logic e;
      acc(1'b0, a, 32'h00000000, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, eexp});
   endtask

   task automatic instr(input logic s, input logic c, input logic r);
      @(posedge ref_clk);
      global_irq_enable_instr <= s;
      global_irq_disable_instr <= c;
      ret <= r;
      @(posedge ref_clk);
      global_irq_enable_instr <= 1'b0;
      global_irq_disable_instr <= 1'b0;
      ret <= 1'b0;
      #1;
   endtask

   task automatic src(input logic [31:0] v);
      @(posedge ref_clk);
      level <= v;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_take(input int lim, output logic hit, output logic [3:0] id,
                            output int n);
      hit = 1'b0;
      id = 4'h0;
      n = 0;
      while (!hit && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
         if (take === 1'b1) begin
            hit = 1'b1;
            id = take_id;
         end
      end
   endtask

   // take expected with id, or none when want is zero
   // fresh: taken from a new edge, else from a bit already latched
   task automatic expect_take(input logic want, input logic [3:0] exp_id, input logic fresh);
      logic hit;
      logic [3:0] id;
      int n;
      wait_take(25, hit, id, n);
      chk({31'h0, hit}, {31'h0, want});
      if (want) begin
         chk({28'h0, id}, {28'h0, exp_id});
         chk({31'h0, n >= (fresh ? int'(evt_ctrl_pkg::MIN_PEND_CYCLES) : 1)}, 32'h1);
      end
   endtask

   task automatic t_reset();
      chk({16'h0, pending}, 32'h0);
      chk({31'h0, global_en}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         rd_chk(i[3:0], 32'h00000000, 1'b0);
      end
      rd_chk(evt_ctrl_pkg::IDX_ASSIGN0, evt_ctrl_pkg::ASSIGN_RST[0], 1'b0);
      rd_chk(4'hA, 32'h00000000, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_access();
      sup <= 1'b0;
      wr(evt_ctrl_pkg::IDX_MASK, 32'h0000FF80);
      chk({31'h0, reg_err}, 32'h1);
      rd_chk(evt_ctrl_pkg::IDX_MASK, 32'h00000000, 1'b1);
      sup <= 1'b1;
      rd_chk(evt_ctrl_pkg::IDX_MASK, 32'h00000000, 1'b0);
      wr(evt_ctrl_pkg::IDX_MASK, 32'hFFFFFF90);
      rd_chk(evt_ctrl_pkg::IDX_MASK, 32'h0000FF80, 1'b0);
      wr(evt_ctrl_pkg::IDX_PENDING, 32'h0000FF80);
      rd_chk(evt_ctrl_pkg::IDX_PENDING, 32'h00000000, 1'b0);
      wr(evt_ctrl_pkg::IDX_MASK, 32'h00000000);
      wr(evt_ctrl_pkg::IDX_LATCH, 32'h00000100);
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000100, 1'b0);
      wr(evt_ctrl_pkg::IDX_LATCH, 32'h00000000);
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000000, 1'b0);
      instr(1'b1, 1'b1, 1'b0);
      chk({31'h0, global_en}, 32'h0);
      $display("test access done");
   endtask

   task automatic t_route();
      wr(evt_ctrl_pkg::IDX_PERIPH_MASK, 32'h00000001);
      rd_chk(evt_ctrl_pkg::IDX_PERIPH_MASK, 32'h00000001, 1'b0);
      wr(evt_ctrl_pkg::IDX_MASK, 32'h0000FF80);
      instr(1'b1, 1'b0, 1'b0);
      chk({31'h0, global_en}, 32'h1);
      src(32'h00000001);
      expect_take(1'b1, 4'h7, 1'b1);
      chk({16'h0, pending}, 32'h00000080);
      idle(8);
      // source still high: a fresh edge waits behind the active level
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000080, 1'b0);
      rd_chk(evt_ctrl_pkg::IDX_PERIPH_STATUS, 32'h00000001, 1'b0);
      instr(1'b0, 1'b0, 1'b1);
      expect_take(1'b1, 4'h7, 1'b0);
      src(32'h00000000);
      instr(1'b0, 1'b0, 1'b1);
      idle(8);
      // the dropped source re-latched once from its acknowledge gap and was taken again
      instr(1'b0, 1'b0, 1'b1);
      idle(2);
      chk({16'h0, pending}, 32'h0);
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000000, 1'b0);
      $display("test route done");
   endtask

   task automatic t_block();
      instr(1'b0, 1'b1, 1'b0);
      src(32'h00000001);
      expect_take(1'b0, 4'h0, 1'b0);
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000080, 1'b0);
      wr(evt_ctrl_pkg::IDX_MASK, 32'h00000000);
      instr(1'b1, 1'b0, 1'b0);
      expect_take(1'b0, 4'h0, 1'b0);
      rd_chk(evt_ctrl_pkg::IDX_LATCH, 32'h00000080, 1'b0);
      wr(evt_ctrl_pkg::IDX_MASK, 32'h0000FF80);
      expect_take(1'b1, 4'h7, 1'b0);
      src(32'h00000000);
      instr(1'b0, 1'b0, 1'b1);
      idle(8);
      instr(1'b0, 1'b0, 1'b1);
      wr(evt_ctrl_pkg::IDX_PERIPH_MASK, 32'h00000000);
      src(32'h00000001);
      expect_take(1'b0, 4'h0, 1'b0);
      rd_chk(evt_ctrl_pkg::IDX_PERIPH_STATUS, 32'h00000001, 1'b0);
      src(32'h00000000);
      idle(6);
      chk({16'h0, pending}, 32'h0);
      $display("test block done");
   endtask

   task automatic t_stall();
      wr(evt_ctrl_pkg::IDX_PERIPH_MASK, 32'h00000001);
      stall <= 1'b1;
      src(32'h00000001);
      expect_take(1'b0, 4'h0, 1'b0);
      stall <= 1'b0;
      expect_take(1'b1, 4'h7, 1'b0);
      src(32'h00000000);
      instr(1'b0, 1'b0, 1'b1);
      idle(8);
      instr(1'b0, 1'b0, 1'b1);
      $display("test stall done");
   endtask

   task automatic t_wake();
      src(32'h00000002);
      idle(8);
      chk({31'h0, wakeup}, 32'h0);
      wr(evt_ctrl_pkg::IDX_WAKEUP_EN, 32'h00000002);
      rd_chk(evt_ctrl_pkg::IDX_WAKEUP_EN, 32'h00000002, 1'b0);
      idle(4);
      chk({31'h0, wakeup}, 32'h1);
      src(32'h00000000);
      idle(8);
      chk({31'h0, wakeup}, 32'h0);
      $display("test wake done");
   endtask

   task automatic t_remap();
      wr(evt_ctrl_pkg::IDX_ASSIGN0, 32'h32111102);
      wr(evt_ctrl_pkg::IDX_PERIPH_MASK, 32'h00000005);
      src(32'h00000005);
      expect_take(1'b1, 4'h8, 1'b1);
      chk({16'h0, pending}, 32'h00000100);
      // drop the level-8 source; its acknowledge gap still re-latches it once
      src(32'h00000001);
      idle(4);
      instr(1'b0, 1'b0, 1'b1);
      expect_take(1'b1, 4'h8, 1'b0);
      instr(1'b0, 1'b0, 1'b1);
      expect_take(1'b1, 4'h9, 1'b0);
      src(32'h00000000);
      $display("test remap done");
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_access();
      t_route();
      t_block();
      t_stall();
      t_wake();
      t_remap();
      tally_and_finish();
   end
endmodule
